// file: inc/adio_pkg.sv
/*
 * adio_pkg: constants, port indices and carrier types for the analyzer
 * digital i/o port block.
 * assumes one 125 MHz clock and an APB master with 32-bit data.
 */
//
// Function
// - internal in/out ports at 322h, mostly spare
// - internal out bit 6 resets serial peripherals
// - internal out bit 7 is bus controller reset_n
// - control in 321h: bits 0-5 pins, 6-7 one
// - input bit 0 low requests calibration mode
// - bit 1 span/zero, bit 2 range select
// - bit 3 selects first or second gas
// - control in 325h: spare, bits 6-7 one
// - control out 321h: eight spare bits
// - out 325h: bits 0-3 spare, 4-7 relays
// - relay bit 4 high only while healthy
// - relay bits 5, 6 are limit alarms
// - relay bit 7 shows auto-range 2
// - relays may follow modbus coils instead
// - status bit 0 low while healthy
// - status bit 1 low while reading valid
// - status bit 2 low while calibrating
// - status bits 3-5 echo span, range, gas
// - status port b at 324h all spare
package adio_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // printed port numbers are indices; byte address is four times each
    localparam logic [9:0] IDX_CTRL_A    = 10'h321;
    localparam logic [9:0] IDX_INTERNAL  = 10'h322;
    localparam logic [9:0] IDX_STATUS_A  = 10'h323;
    localparam logic [9:0] IDX_STATUS_B  = 10'h324;
    localparam logic [9:0] IDX_CTRL_B    = 10'h325;
    localparam logic [9:0] IDX_RELAY_CFG = 10'h326;

    localparam int INT_PERIPH_RST_BIT = 6;
    localparam int INT_BUS_RST_N_BIT  = 7;
    localparam int RELAY_LSB          = 4;
    localparam int RELAY_CFG_COIL_BIT = 0;

    localparam logic [7:0] FIXED_ONES   = 8'hc0;
    localparam logic [7:0] RST_INTERNAL = 8'h40;
    localparam logic [7:0] RST_CTRL_A   = 8'h00;
    localparam logic [7:0] RST_STATUS_A = 8'h07;
    localparam logic [7:0] RST_STATUS_B = 8'h00;
    localparam logic [7:0] RST_ALARM    = 8'h00;
    localparam logic [7:0] RST_RELAY_CFG = 8'h00;

    typedef struct packed {
        logic ext_gas_select;
        logic ext_range_select;
        logic ext_span_zero_select;
        logic ext_calibrate_request_n;
    } adio_cal_in_t;

    typedef struct packed {
        logic autorange_indicator;
        logic limit_two_alarm;
        logic limit_one_alarm;
        logic health_relay;
    } adio_relay_t;

    typedef struct packed {
        logic coil_relay_d;
        logic coil_relay_c;
        logic coil_relay_b;
        logic coil_relay_a;
    } adio_coil_t;

    typedef struct packed {
        logic [1:0] spare;
        logic       gas_status;
        logic       range_status;
        logic       span_zero_status;
        logic       calibrating_status_n;
        logic       reading_valid_n;
        logic       health_status_n;
    } adio_status_t;

endpackage

// file: rtl/adio_ports.sv
/*
 * adio_ports: APB slave holding the analyzer digital input and output
 * ports, the status latches and the alarm relay drive with coil override.
 * assumes pins already synchronous to pclk and an APB master that holds
 * each request until pready.
 */
module adio_ports (
    // clock and reset
    input  wire  logic                      pclk,
    input  wire  logic                      presetn,
    // apb slave
    input  wire  logic                      psel,
    input  wire  logic                      penable,
    input  wire  logic                      pwrite,
    input  wire  logic [adio_pkg::ADDR_W-1:0] paddr,
    input  wire  logic [adio_pkg::DATA_W-1:0] pwdata,
    output logic [adio_pkg::DATA_W-1:0]       prdata,
    output logic                            pready,
    output logic                            pslverr,
    // contact closure and spare inputs
    input  wire  adio_pkg::adio_cal_in_t    ext_cal,
    input  wire  logic [1:0]                ctrl_a_spare_in,
    input  wire  logic [5:0]                ctrl_b_spare_in,
    input  wire  logic [7:0]                internal_in,
    // modbus coils
    input  wire  adio_pkg::adio_coil_t      coil_in,
    // serial peripheral resets and internal spare outputs
    output logic                            periph_reset,
    output logic                            bus_controller_hw_reset_n,
    output logic [5:0]                      internal_spare_out,
    // control, status and relay outputs
    output logic [7:0]                      ctrl_a_out,
    output logic [3:0]                      ctrl_b_spare_out,
    output adio_pkg::adio_relay_t           relay_out,
    output adio_pkg::adio_status_t          status_a_out,
    output logic [7:0]                      status_b_out
);
    import adio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [9:0]        idx);
        hit = (a == {idx, 2'b00});
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, IDX_CTRL_A) || hit(a, IDX_INTERNAL) ||
                 hit(a, IDX_STATUS_A) || hit(a, IDX_STATUS_B) ||
                 hit(a, IDX_CTRL_B) || hit(a, IDX_RELAY_CFG);
    endfunction

    logic        setup;
    logic        access;
    logic        wr_take;
    logic [7:0]  wbyte;
    logic [7:0]  internal_q;
    logic [7:0]  alarm_q;
    logic [7:0]  relay_cfg_q;
    logic [7:0]  next_rd;
    logic        coil_mode;

    assign setup     = psel && !penable;
    assign access    = psel && penable && pready;
    assign wr_take   = access && pwrite && mapped(paddr);
    assign wbyte     = pwdata[7:0];
    assign coil_mode = relay_cfg_q[RELAY_CFG_COIL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait-free access phase, answered from flops

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped(paddr);
        end
    end

    // read mux; shared indices return pins, not the latch
    always_comb begin
        next_rd = 8'h00;
        if (hit(paddr, IDX_CTRL_A)) begin
            // contacts on bits 3:0
            next_rd = FIXED_ONES | {2'b00, ctrl_a_spare_in, ext_cal};
        end else if (hit(paddr, IDX_INTERNAL)) begin
            next_rd = internal_in;
        end else if (hit(paddr, IDX_STATUS_A)) begin
            next_rd = status_a_out;
        end else if (hit(paddr, IDX_STATUS_B)) begin
            next_rd = status_b_out;
        end else if (hit(paddr, IDX_CTRL_B)) begin
            next_rd = FIXED_ONES | {2'b00, ctrl_b_spare_in};
        end else if (hit(paddr, IDX_RELAY_CFG)) begin
            next_rd = {relay_out, 3'b000, coil_mode};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            prdata <= {{(DATA_W-8){1'b0}}, next_rd};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal port: peripheral resets

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_q <= RST_INTERNAL;
        end else if (wr_take && hit(paddr, IDX_INTERNAL)) begin
            internal_q <= wbyte;
        end
    end

    // reset holds peripherals and the bus controller down until software
    // releases them
    assign periph_reset              = internal_q[INT_PERIPH_RST_BIT];
    assign bus_controller_hw_reset_n = internal_q[INT_BUS_RST_N_BIT];
    assign internal_spare_out        = internal_q[5:0];

    ////////////////////////////////////////////////////////////////////////
    // control and status latches

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_out <= RST_CTRL_A;
        end else if (wr_take && hit(paddr, IDX_CTRL_A)) begin
            ctrl_a_out <= wbyte;
        end
    end

    // firmware writes the health, validity and calibration echo bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_a_out <= RST_STATUS_A;
        end else if (wr_take && hit(paddr, IDX_STATUS_A)) begin
            status_a_out <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_b_out <= RST_STATUS_B;
        end else if (wr_take && hit(paddr, IDX_STATUS_B)) begin
            status_b_out <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm relays with coil override

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_q <= RST_ALARM;
        end else if (wr_take && hit(paddr, IDX_CTRL_B)) begin
            alarm_q <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_cfg_q <= RST_RELAY_CFG;
        end else if (wr_take && hit(paddr, IDX_RELAY_CFG)) begin
            relay_cfg_q <= {7'h00, wbyte[RELAY_CFG_COIL_BIT]};
        end
    end

    assign ctrl_b_spare_out = alarm_q[3:0];

    // relay pins re-registered so a coil change lands one clock later,
    // never glitching through the mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_out <= '0;
        end else if (coil_mode) begin
            relay_out <= coil_in;
        end else begin
            relay_out <= alarm_q[7:RELAY_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    a_ready_after_setup: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no answer one cycle after setup");

    a_unmapped_error: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable && !mapped(paddr)) |=> (pready && pslverr))
        else $error("unmapped address not flagged");

    a_internal_read: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_INTERNAL))
        |-> prdata[7:0] == $past(internal_in))
        else $error("internal input read mismatch");

    a_periph_reset_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_INTERNAL))
        |=> periph_reset == $past(pwdata[6]))
        else $error("peripheral reset not taken from bit 6");

    a_bus_reset_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_INTERNAL))
        |=> bus_controller_hw_reset_n == $past(pwdata[7]))
        else $error("bus controller reset not taken from bit 7");

    a_ctrl_a_ones: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_CTRL_A))
        |-> prdata[7:6] == 2'b11 && prdata[31:8] == '0)
        else $error("control input a top bits not one");

    a_ctrl_a_pins: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_CTRL_A))
        |-> prdata[3:0] == $past(ext_cal))
        else $error("calibration contacts not on bits 0-3");

    a_ctrl_b_read: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_CTRL_B))
        |-> prdata[7:0] == {2'b11, $past(ctrl_b_spare_in)})
        else $error("control input b read mismatch");

    a_ctrl_a_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_CTRL_A))
        |=> ctrl_a_out == $past(pwdata[7:0]))
        else $error("control output a not latched");

    a_relay_latch: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_CTRL_B) && !coil_mode)
        |=> ##1 relay_out == $past(pwdata[7:4], 2))
        else $error("relay pins not following alarm latch");

    a_relay_coil: assert property (@(posedge pclk)
        disable iff (!presetn)
        coil_mode |=> relay_out == $past(coil_in))
        else $error("relay pins not following coils");

    a_status_a_wr: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_STATUS_A))
        |=> status_a_out == $past(pwdata[7:0]))
        else $error("status a not latched");

    a_status_b_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(access && pwrite && hit(paddr, IDX_STATUS_B))
        |=> $stable(status_b_out))
        else $error("status b changed without a write");

    a_shared_no_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_INTERNAL))
        |=> $stable(internal_q))
        else $error("read disturbed internal output latch");

    a_upper_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        access
        |-> prdata[31:8] == '0)
        else $error("read data upper bits not zero");

    a_unmapped_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && !mapped(paddr))
        |-> prdata == '0)
        else $error("unmapped read returned data");

    a_mapped_no_err: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable && mapped(paddr))
        |=> (pready && !pslverr))
        else $error("mapped address flagged as error");

    a_unmapped_no_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && !mapped(paddr))
        |=> $stable(internal_q) && $stable(ctrl_a_out) && $stable(alarm_q))
        else $error("unmapped write changed a latch");

    a_spare_out_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_INTERNAL))
        |=> internal_spare_out == $past(pwdata[5:0]))
        else $error("internal spare outputs not latched");

    a_ctrl_b_out_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_CTRL_B))
        |=> ctrl_b_spare_out == $past(pwdata[3:0]))
        else $error("spare control outputs not latched");

    a_ctrl_a_spare: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_CTRL_A))
        |-> prdata[5:4] == $past(ctrl_a_spare_in))
        else $error("spare control inputs not on bits 4-5");

    a_status_b_wr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && pwrite && hit(paddr, IDX_STATUS_B))
        |=> status_b_out == $past(pwdata[7:0]))
        else $error("status b not latched");

    a_status_a_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit(paddr, IDX_STATUS_A))
        |=> $stable(status_a_out))
        else $error("status a changed without a write");

    a_ctrl_a_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(access && pwrite && hit(paddr, IDX_CTRL_A))
        |=> $stable(ctrl_a_out))
        else $error("control output a changed without a write");

    a_internal_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(access && pwrite && hit(paddr, IDX_INTERNAL))
        |=> $stable(internal_q))
        else $error("reset outputs changed without a write");

    a_relay_cfg_read: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_RELAY_CFG))
        |-> prdata[7:0] == {$past(relay_out), 3'b000, $past(coil_mode)})
        else $error("relay configuration read mismatch");

    a_relay_alarm: assert property (@(posedge pclk)
        disable iff (!presetn)
        !coil_mode |=> relay_out == $past(alarm_q[7:RELAY_LSB]))
        else $error("relay pins not following alarm latch");

    a_status_a_read: assert property (@(posedge pclk)
        disable iff (!presetn)
        (access && !pwrite && hit(paddr, IDX_STATUS_A))
        |-> prdata[7:0] == $past(status_a_out))
        else $error("status a read mismatch");

    c_cal_read: cover property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && hit(paddr, IDX_CTRL_A) && !prdata[0]);

    c_coil_mode: cover property (@(posedge pclk) disable iff (!presetn)
        coil_mode ##1 relay_out == 4'hf);

    c_release_reset: cover property (@(posedge pclk) disable iff (!presetn)
        !bus_controller_hw_reset_n ##1 bus_controller_hw_reset_n);

    c_back_to_back: cover property (@(posedge pclk) disable iff (!presetn)
        access ##1 (psel && !penable) ##1 access);

    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);

endmodule // adio_ports

// file: tb/adio_host.sv
/*
 * adio_host: apb master standing in for the host processor.
 * assumes pclk from the bench and a slave that answers with pready.
 */
module adio_host (
    // clock
    input  wire logic                        pclk,
    // apb master
    output logic                             psel,
    output logic                             penable,
    output logic                             pwrite,
    output logic [adio_pkg::ADDR_W-1:0]      paddr,
    output logic [adio_pkg::DATA_W-1:0]      pwdata,
    input  wire logic [adio_pkg::DATA_W-1:0] prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    import adio_pkg::*;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // one transfer; to is set when no answer came within the bound
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] rd, output logic err,
                        output logic to);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        to = 1'b1;
        rd = '0;
        err = 1'b0;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                to = 1'b0;
                rd = prdata;
                err = pslverr;
                break;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines show no stale value
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask

endmodule // adio_host

// file: tb/analyzer_digital_io_ports_test.sv
/*
 * analyzer_digital_io_ports_test: directed bench for adio_ports.
 * assumes the host model for apb and drives all pins itself.
 */
module analyzer_digital_io_ports_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adio_pkg::*;

    localparam logic [11:0] A_CA = {IDX_CTRL_A, 2'b00};
    localparam logic [11:0] A_IN = {IDX_INTERNAL, 2'b00};
    localparam logic [11:0] A_SA = {IDX_STATUS_A, 2'b00};
    localparam logic [11:0] A_SB = {IDX_STATUS_B, 2'b00};
    localparam logic [11:0] A_CB = {IDX_CTRL_B, 2'b00};
    localparam logic [11:0] A_RC = {IDX_RELAY_CFG, 2'b00};

    logic pclk = 1'b0, presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    adio_cal_in_t ext_cal = '0;
    adio_coil_t coil_in = '0;
    logic [1:0] ctrl_a_spare_in = '0;
    logic [5:0] ctrl_b_spare_in = '0;
    logic [7:0] internal_in = '0;
    logic periph_reset, bus_controller_hw_reset_n;
    logic [5:0] internal_spare_out;
    logic [7:0] ctrl_a_out, status_b_out;
    logic [3:0] ctrl_b_spare_out;
    adio_relay_t relay_out;
    adio_status_t status_a_out;
    int errors = 0, n_tests = 0;

    initial forever #4 pclk = ~pclk;

    adio_host u_adio_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    adio_ports u_adio_ports (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_cal(ext_cal),
        .ctrl_a_spare_in(ctrl_a_spare_in),
        .ctrl_b_spare_in(ctrl_b_spare_in), .internal_in(internal_in),
        .coil_in(coil_in), .periph_reset(periph_reset),
        .bus_controller_hw_reset_n(bus_controller_hw_reset_n),
        .internal_spare_out(internal_spare_out), .ctrl_a_out(ctrl_a_out),
        .ctrl_b_spare_out(ctrl_b_spare_out), .relay_out(relay_out),
        .status_a_out(status_a_out), .status_b_out(status_b_out));

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [31:0] exp,
                        input logic exp_err);
        logic [31:0] rd;
        logic err, to;
        u_adio_host.xfer(w, a, d, rd, err, to);
        if (to) begin
            errors++;
            $display("BAD at %0t: no answer", $time);
            tally_and_finish();
        end else begin
            check({31'h0, err}, {31'h0, exp_err});
            if (!w) check(rd, exp);
        end
    endtask

    // past the relay update one cycle after the latch
    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({24'h0, status_a_out}, {24'h0, RST_STATUS_A});
        check({30'h0, periph_reset, bus_controller_hw_reset_n}, 2);
        check({20'h0, ctrl_a_out, relay_out}, 0);
        $display("test reset done");
        xfer(1, A_IN, 32'h80, 0, 0);
        settle();
        check({30'h0, periph_reset, bus_controller_hw_reset_n}, 1);
        xfer(1, A_IN, 32'h7f, 0, 0);
        settle();
        check({periph_reset, bus_controller_hw_reset_n,
               internal_spare_out}, 8'hbf);
        @(posedge pclk);
        internal_in <= 8'h5a;
        xfer(0, A_IN, 0, 32'h5a, 0);
        $display("test internal port done");
        for (int k = 0; k < 16; k++) begin
            ext_cal <= adio_cal_in_t'(k[3:0]);
            ctrl_a_spare_in <= k[1:0] ^ 2'b01;
            xfer(0, A_CA, 0, {24'h0, 2'b11, k[1:0] ^ 2'b01, k[3:0]},
                 0);
        end
        ctrl_b_spare_in <= 6'h2d;
        xfer(0, A_CB, 0, 32'hed, 0);
        xfer(1, A_CA, 32'ha5, 0, 0);
        settle();
        check({24'h0, ctrl_a_out}, 32'ha5);
        $display("test control ports done");
        for (int k = 0; k < 16; k++) begin
            xfer(1, A_CB, {24'h0, k[3:0], ~k[3:0]}, 0, 0);
            settle();
            check({ctrl_b_spare_out, relay_out},
                  {~k[3:0], k[3:0]});
        end
        coil_in <= adio_coil_t'(4'h9);
        xfer(1, A_RC, 1, 0, 0);
        settle();
        check({28'h0, relay_out}, 32'h9);
        xfer(0, A_RC, 0, 32'h91, 0);
        @(posedge pclk);
        coil_in <= adio_coil_t'(4'h6);
        settle();
        check({28'h0, relay_out}, 32'h6);
        xfer(1, A_RC, 0, 0, 0);
        settle();
        check({28'h0, relay_out}, 32'hf);
        $display("test relays done");
        xfer(1, A_SA, 32'h2a, 0, 0);
        xfer(1, A_SB, 32'h33, 0, 0);
        settle();
        check({status_b_out, status_a_out}, 16'h332a);
        xfer(0, A_SA, 0, 32'h2a, 0);
        // unmapped place answers with an error and drops the write
        xfer(1, 12'hffc, 32'h11, 0, 1);
        xfer(0, 12'hffc, 0, 0, 1);
        settle();
        check({status_b_out, status_a_out}, 16'h332a);
        $display("test status done");
        // mid-run reset must bring the status, control a, reset and relay latches back to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({24'h0, status_a_out}, {24'h0, RST_STATUS_A});
        check({status_b_out, 20'h0, relay_out}, 0);
        check({30'h0, periph_reset, bus_controller_hw_reset_n}, 2);
        check({24'h0, ctrl_a_out}, 0);
        xfer(0, A_RC, 0, 0, 0);
        $display("test mid-run reset done");
        tally_and_finish();
    end

endmodule // analyzer_digital_io_ports_test
